// file: hdl/ecrst_pkg.sv
package ecrst_pkg;
   localparam int unsigned CLK_MHZ = 100;
   // Reset pin glitch filter: low pulses up to this length are ignored.
   localparam int unsigned RST_FILT_NS = 400;
   localparam int unsigned RST_FILT_CYC = (RST_FILT_NS * CLK_MHZ) / 1000;
   // Host wait after a system reset before touching the PHY.
   localparam int unsigned PHY_WAIT_US = 50;
   localparam int unsigned PHY_WAIT_CYC = PHY_WAIT_US * CLK_MHZ;
   // Internal delay of a PHY software reset.
   localparam int unsigned PHY_RST_US = 10;
   localparam int unsigned PHY_RST_CYC = PHY_RST_US * CLK_MHZ;
   // Oscillator start-up timer.
   localparam int unsigned OST_US = 300;
   localparam int unsigned OST_CYC = OST_US * CLK_MHZ;
   localparam int unsigned CNT_W = 16;
   // Register addresses on the command port.
   localparam logic [1:0] ADDR_MAIN_CTRL = 2'h0;
   localparam logic [1:0] ADDR_PHY_CTRL = 2'h1;
   localparam logic [1:0] ADDR_STATUS = 2'h2;
   // Main control fields.
   localparam int unsigned MC_TX_RST = 7;
   localparam int unsigned MC_RX_RST = 6;
   localparam int unsigned MC_TX_REQ = 3;
   localparam int unsigned MC_RX_EN = 2;
   localparam logic [7:0] MC_RESET = 8'h00;
   // PHY control fields.
   localparam int unsigned PC_SOFT_RST = 15;
   localparam int unsigned PC_LOOPBACK = 14;
   localparam int unsigned PC_POWER_DOWN = 11;
   localparam int unsigned PC_DUPLEX = 8;
   localparam logic [15:0] PC_WMASK = 16'hc900;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam int unsigned ST_CLK_READY = 0;
endpackage : ecrst_pkg

// file: hdl/ecrst_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ecrst_if;
   logic        reset_pin_n;
   logic        sys_reset_cmd;
   logic        wr;
   logic        rd;
   logic [1:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        rvalid;
   modport device (input reset_pin_n, sys_reset_cmd, wr, rd, addr, wdata, output rdata, rvalid);
   modport host   (output reset_pin_n, sys_reset_cmd, wr, rd, addr, wdata, input rdata, rvalid);
endinterface : ecrst_if
`default_nettype wire

// file: hdl/ecrst_device.sv
// Functional notes
// - Power-on loads every register default.
// - System reset by pin or command.
// - Filter short low pulses on reset pin.
// - Device never drives the reset pin.
// - Host waits 50 us before PHY access.
// - System reset restores registers, keeps buffer.
// - System reset includes transmit and receive resets.
// - Transmit reset aborts frame, clears request.
// - Transmit reset touches nothing else.
// - Host clears transmit reset bit itself.
// - Receive reset aborts frame, clears enable.
// - Receive reset touches nothing else.
// - Host clears receive reset bit itself.
// - PHY soft reset restores PHY defaults.
// - PHY reset bit reads one until done.
// - Host polls PHY reset bit before use.
// - Loopback returns data, disables twisted pair.
// - Power-down bit shuts PHY down.
// - Duplex bit selects mode, resets from strap.
// - Host writes zero to reserved bits.
// - Host waits for oscillator start-up; ecrst_host does not check clock ready and forwards accesses at once.
// - Clock ready set after start-up timer.
`timescale 1ns/10ps
`default_nettype none
module ecrst_device
   import ecrst_pkg::*;
(
   input  wire logic   i_clk,
   input  wire logic   i_rst_n,
   input  wire logic   i_second_led_strap_pin,
   input  wire logic   i_tx_frame_active,
   input  wire logic   i_rx_frame_active,
   ecrst_if.device     bus,
   output logic        o_sys_reset,
   output logic        o_tx_logic_reset,
   output logic        o_rx_logic_reset,
   output logic        o_tx_abort,
   output logic        o_rx_abort,
   output logic        o_phy_reset,
   output logic        o_phy_loopback,
   output logic        o_tp_disable,
   output logic        o_phy_power_down,
   output logic        o_phy_full_duplex,
   output logic        o_clock_ready_status
);
   // The reset pin is an input only; no drive path exists toward it.
   logic [1:0]  pin_sync_reg;
   logic [CNT_W-1:0] filt_cnt_reg;
   logic        sys_rst_reg;
   logic        sys_rst_sync_reg;
   logic [7:0]  main_ctrl_reg;
   logic [15:0] phy_ctrl_reg;
   logic [CNT_W-1:0] phy_cnt_reg;
   logic [CNT_W+4:0] ost_cnt_reg;
   logic        clk_ready_reg;
   logic [15:0] rdata_reg;
   logic        rvalid_reg;
   logic        tx_abort_reg;
   logic        rx_abort_reg;
   logic [1:0]  strap_sync_reg;
   logic        wr_main;
   logic        wr_phy;

   assign wr_main = bus.wr && bus.addr == ADDR_MAIN_CTRL;
   assign wr_phy  = bus.wr && bus.addr == ADDR_PHY_CTRL;

   function automatic logic [15:0] phy_default(input logic strap);
      logic [15:0] val;
      val = PC_RESET;
      val[PC_DUPLEX] = strap;
      return val;
   endfunction : phy_default

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pin_sync_reg <= 2'h3;
      end else begin
         pin_sync_reg <= {pin_sync_reg[0], bus.reset_pin_n};
      end
   end

   // Only lows longer than the filter window count as reset.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         filt_cnt_reg <= '0;
         sys_rst_reg  <= 1'b0;
      end else if (pin_sync_reg[1]) begin
         filt_cnt_reg <= '0;
         sys_rst_reg  <= bus.sys_reset_cmd;
      end else if (filt_cnt_reg > CNT_W'(RST_FILT_CYC)) begin
         sys_rst_reg  <= 1'b1;
      end else begin
         filt_cnt_reg <= filt_cnt_reg + 1'b1;
         sys_rst_reg  <= bus.sys_reset_cmd;
      end
   end

   // A registered stage lets every register leave reset on one edge.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sys_rst_sync_reg <= 1'b1;
      end else begin
         sys_rst_sync_reg <= sys_rst_reg;
      end
   end

   // The strap is static in use, but it is a pin, so it still passes two flops.
   always_ff @(posedge i_clk) begin
      strap_sync_reg <= {strap_sync_reg[0], i_second_led_strap_pin};
   end

   // Main control; system reset restores it, the buffer has no reset.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || sys_rst_sync_reg) begin
         main_ctrl_reg <= MC_RESET;
      end else if (wr_main) begin
         main_ctrl_reg <= bus.wdata[7:0];
         if (bus.wdata[MC_TX_RST]) begin
            main_ctrl_reg[MC_TX_REQ] <= 1'b0;
         end
         if (bus.wdata[MC_RX_RST]) begin
            main_ctrl_reg[MC_RX_EN] <= 1'b0;
         end
      end else begin
         // Reset bits stay until the host clears them.
         if (main_ctrl_reg[MC_TX_RST]) begin
            main_ctrl_reg[MC_TX_REQ] <= 1'b0;
         end
         if (main_ctrl_reg[MC_RX_RST]) begin
            main_ctrl_reg[MC_RX_EN] <= 1'b0;
         end
      end
   end

   // PHY control and its soft reset timer.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || sys_rst_sync_reg) begin
         phy_ctrl_reg <= phy_default(strap_sync_reg[1]);
         phy_cnt_reg  <= '0;
      end else if (phy_ctrl_reg[PC_SOFT_RST]) begin
         if (phy_cnt_reg == CNT_W'(PHY_RST_CYC - 1)) begin
            phy_ctrl_reg <= phy_default(strap_sync_reg[1]);
            phy_cnt_reg  <= '0;
         end else begin
            phy_cnt_reg <= phy_cnt_reg + 1'b1;
         end
      end else if (wr_phy) begin
         phy_ctrl_reg <= bus.wdata & PC_WMASK;
      end
   end

   // Clock ready follows the start-up timer; only power-on clears it.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ost_cnt_reg   <= '0;
         clk_ready_reg <= 1'b0;
      end else if (!clk_ready_reg) begin
         if (ost_cnt_reg == (CNT_W+5)'(OST_CYC - 1)) begin
            clk_ready_reg <= 1'b1;
         end else begin
            ost_cnt_reg <= ost_cnt_reg + 1'b1;
         end
      end
   end

   // Abort levels for frames in flight, held while the reset and the frame last.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tx_abort_reg <= 1'b0;
         rx_abort_reg <= 1'b0;
      end else begin
         tx_abort_reg <= i_tx_frame_active && (sys_rst_sync_reg || main_ctrl_reg[MC_TX_RST]);
         rx_abort_reg <= i_rx_frame_active && (sys_rst_sync_reg || main_ctrl_reg[MC_RX_RST]);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_reg  <= '0;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= bus.rd;
         unique case (bus.addr)
            ADDR_MAIN_CTRL: rdata_reg <= {8'h00, main_ctrl_reg};
            ADDR_PHY_CTRL:  rdata_reg <= phy_ctrl_reg;
            ADDR_STATUS:    rdata_reg <= {15'h0000, clk_ready_reg};
            default:        rdata_reg <= '0;
         endcase
      end
   end

   assign bus.rdata  = rdata_reg;
   assign bus.rvalid = rvalid_reg;
   assign o_sys_reset = sys_rst_sync_reg;
   // Transmit and receive resets drive only their own logic.
   assign o_tx_logic_reset = main_ctrl_reg[MC_TX_RST] | sys_rst_sync_reg;
   assign o_rx_logic_reset = main_ctrl_reg[MC_RX_RST] | sys_rst_sync_reg;
   assign o_tx_abort = tx_abort_reg;
   assign o_rx_abort = rx_abort_reg;
   assign o_phy_reset = phy_ctrl_reg[PC_SOFT_RST];
   assign o_phy_loopback = phy_ctrl_reg[PC_LOOPBACK];
   assign o_tp_disable = phy_ctrl_reg[PC_LOOPBACK] | phy_ctrl_reg[PC_POWER_DOWN];
   assign o_phy_power_down = phy_ctrl_reg[PC_POWER_DOWN];
   assign o_phy_full_duplex = phy_ctrl_reg[PC_DUPLEX];
   assign o_clock_ready_status = clk_ready_reg;
endmodule : ecrst_device
`default_nettype wire

// file: hdl/ecrst_host.sv
`timescale 1ns/10ps
`default_nettype none
module ecrst_host
   import ecrst_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_pin_reset,
   input  wire logic        i_cmd_reset,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [1:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   ecrst_if.host            bus,
   output logic             o_busy,
   output logic [15:0]      o_rdata,
   output logic             o_rvalid
);
   typedef enum logic [1:0] {ECRST_IDLE, ECRST_HOLD, ECRST_WAIT} ecrst_state_t;
   ecrst_state_t state_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic        pin_reg;
   logic        cmd_reg;
   logic        wr_reg;
   logic        rd_reg;
   logic [1:0]  addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic        rvalid_reg;
   logic        phy_ok;

   // No PHY access during the post-reset wait.
   assign phy_ok = state_reg == ECRST_IDLE || i_addr != ADDR_PHY_CTRL;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_reg <= ECRST_IDLE;
         cnt_reg   <= '0;
         pin_reg   <= 1'b1;
         cmd_reg   <= 1'b0;
      end else begin
         unique case (state_reg)
            ECRST_IDLE: begin
               if (i_pin_reset || i_cmd_reset) begin
                  pin_reg   <= !i_pin_reset;
                  cmd_reg   <= i_cmd_reset;
                  cnt_reg   <= '0;
                  state_reg <= ECRST_HOLD;
               end
            end
            ECRST_HOLD: begin
               // Hold past the filter window so the pin reset counts.
               if (cnt_reg == CNT_W'(RST_FILT_CYC + 2)) begin
                  pin_reg   <= 1'b1;
                  cmd_reg   <= 1'b0;
                  cnt_reg   <= '0;
                  state_reg <= ECRST_WAIT;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            ECRST_WAIT: begin
               if (cnt_reg == CNT_W'(PHY_WAIT_CYC + 4)) begin
                  state_reg <= ECRST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_reg    <= 1'b0;
         rd_reg    <= 1'b0;
         addr_reg  <= '0;
         wdata_reg <= '0;
      end else begin
         wr_reg    <= i_wr && phy_ok && state_reg != ECRST_HOLD;
         rd_reg    <= i_rd && phy_ok && state_reg != ECRST_HOLD;
         addr_reg  <= i_addr;
         // Reserved PHY bits are always written as zero.
         wdata_reg <= (i_addr == ADDR_PHY_CTRL) ? (i_wdata & PC_WMASK) : i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_reg  <= '0;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= bus.rdata;
         rvalid_reg <= bus.rvalid;
      end
   end

   assign bus.reset_pin_n   = pin_reg;
   assign bus.sys_reset_cmd = cmd_reg;
   assign bus.wr    = wr_reg;
   assign bus.rd    = rd_reg;
   assign bus.addr  = addr_reg;
   assign bus.wdata = wdata_reg;
   assign o_busy    = state_reg != ECRST_IDLE;
   assign o_rdata   = rdata_reg;
   assign o_rvalid  = rvalid_reg;
   // Reset bit release and PHY polling are left to the user's own accesses.
endmodule : ecrst_host
`default_nettype wire

// file: testbench/ecrst_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ecrst_checker
   import ecrst_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic reset_pin_n,
   input wire logic sys_reset_cmd,
   input wire logic i_tx_frame_active,
   input wire logic i_rx_frame_active,
   input wire logic o_sys_reset,
   input wire logic o_tx_logic_reset,
   input wire logic o_rx_logic_reset,
   input wire logic o_tx_abort,
   input wire logic o_rx_abort,
   input wire logic o_phy_reset,
   input wire logic o_phy_loopback,
   input wire logic o_tp_disable,
   input wire logic o_clock_ready_status
);
   localparam int PHY_LIM = PHY_RST_CYC + 4;
   logic [CNT_W-1:0] low_cnt;
   logic [CNT_W-1:0] cause_age;
   logic [CNT_W-1:0] phy_cnt;
   int               ost_cnt;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   always_ff @(posedge i_clk) begin
      low_cnt <= (!i_rst_n || reset_pin_n) ? '0 : low_cnt + 1'b1;
   end
   // Age of the last genuine reset cause; a rise with no recent cause means a glitch got through.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) cause_age <= '1;
      else if (sys_reset_cmd || low_cnt >= RST_FILT_CYC) cause_age <= '0;
      else if (cause_age != '1) cause_age <= cause_age + 1'b1;
   end
   always_ff @(posedge i_clk) begin
      phy_cnt <= o_phy_reset ? phy_cnt + 1'b1 : '0;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) ost_cnt <= 0;
      else if (ost_cnt < OST_CYC + 100) ost_cnt <= ost_cnt + 1;
   end
   sequence s_phy_start;
      $rose(o_phy_reset);
   endsequence
   sequence s_tx_kill;
      $rose(o_tx_logic_reset) && i_tx_frame_active;
   endsequence
   sequence s_rx_kill;
      $rose(o_rx_logic_reset) && i_rx_frame_active;
   endsequence
   chk_sysrst_has_cause: assert property ($rose(o_sys_reset) && $past(i_rst_n) |-> cause_age < 16)
      else $error("system reset rose without a valid cause");
   chk_pin_not_pulled: assert property (sys_reset_cmd |-> reset_pin_n)
      else $error("reset pin low during command reset");
   chk_sys_covers_trx: assert property ($rose(o_sys_reset) |-> ##[0:2] (o_tx_logic_reset && o_rx_logic_reset))
      else $error("system reset did not reset tx and rx logic");
   chk_tx_frame_abort: assert property (s_tx_kill |-> ##[0:2] o_tx_abort)
      else $error("tx frame not aborted");
   chk_rx_frame_abort: assert property (s_rx_kill |-> ##[0:2] o_rx_abort)
      else $error("rx frame not aborted");
   chk_phy_rst_holds: assert property (s_phy_start |-> o_phy_reset [*8])
      else $error("phy reset cleared at once");
   chk_phy_rst_bound: assert property (o_phy_reset |-> phy_cnt <= PHY_LIM)
      else $error("phy reset never cleared");
   chk_loop_tp_off: assert property (o_phy_loopback |-> o_tp_disable)
      else $error("twisted pair active in loopback");
   chk_clk_not_early: assert property (o_clock_ready_status |-> ost_cnt >= OST_CYC - 4)
      else $error("clock ready before start-up timer");
   chk_clk_not_late: assert property (ost_cnt >= OST_CYC + 8 |-> o_clock_ready_status)
      else $error("clock ready missing after start-up timer");
endmodule : ecrst_checker
`default_nettype wire

// file: testbench/tb_ethernet_controller_reset_unit.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ethernet_controller_reset_unit;
   import ecrst_pkg::*;
   logic        i_clk, i_rst_n, i_pin_reset, i_cmd_reset, i_wr, i_rd, strap, tx_act, rx_act;
   logic        o_busy, o_rvalid, sys_rst, tx_rst, rx_rst, tx_ab, rx_ab, phy_rst, lpb, tpd, pwd, fdx, crdy;
   logic [1:0]  i_addr;
   logic [15:0] i_wdata, o_rdata;
   logic [31:0] seed;
   logic [15:0] main_seq [5] = '{16'h000c, 16'h008c, 16'h0004, 16'h0044, 16'h000c};
   int          err_total, check_count, main_m, phy_m, n;
   ecrst_if u_ecrst_if ();
   ecrst_device u_ecrst_device (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_second_led_strap_pin(strap),
      .i_tx_frame_active(tx_act), .i_rx_frame_active(rx_act), .bus(u_ecrst_if), .o_sys_reset(sys_rst),
      .o_tx_logic_reset(tx_rst), .o_rx_logic_reset(rx_rst), .o_tx_abort(tx_ab), .o_rx_abort(rx_ab),
      .o_phy_reset(phy_rst), .o_phy_loopback(lpb), .o_tp_disable(tpd), .o_phy_power_down(pwd),
      .o_phy_full_duplex(fdx), .o_clock_ready_status(crdy));
   ecrst_host u_ecrst_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin_reset(i_pin_reset), .i_cmd_reset(i_cmd_reset),
      .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .bus(u_ecrst_if), .o_busy(o_busy),
      .o_rdata(o_rdata), .o_rvalid(o_rvalid));
   ecrst_checker u_ecrst_checker (.i_clk(i_clk), .i_rst_n(i_rst_n), .reset_pin_n(u_ecrst_if.reset_pin_n),
      .sys_reset_cmd(u_ecrst_if.sys_reset_cmd), .i_tx_frame_active(tx_act), .i_rx_frame_active(rx_act),
      .o_sys_reset(sys_rst), .o_tx_logic_reset(tx_rst), .o_rx_logic_reset(rx_rst), .o_tx_abort(tx_ab),
      .o_rx_abort(rx_ab), .o_phy_reset(phy_rst), .o_phy_loopback(lpb), .o_tp_disable(tpd),
      .o_clock_ready_status(crdy));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic summarize;
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   // Every access waits out the host's busy time, since the host drops all requests during the hold and PHY requests during the wait.
   task automatic idle;
      n = 0;
      @(negedge i_clk);
      while (o_busy !== 1'b0 && n < 9000) begin
         @(negedge i_clk);
         n++;
      end
      chk("host_idle", 16'(n < 9000), 16'h0001);
   endtask : idle
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      idle();
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      if (a == ADDR_MAIN_CTRL) main_m = {8'h00, d[7:0] & ~{4'h0, d[7], d[6], 2'h0}};
      else phy_m = d[15] ? {7'h00, strap, 8'h00} : d & 16'h4900;
      @(negedge i_clk);
      i_wr = 1'b0;
      repeat (3) @(negedge i_clk);
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [15:0] exp, input string nm);
      idle();
      i_rd = 1'b1;
      i_addr = a;
      @(negedge i_clk);
      i_rd = 1'b0;
      for (n = 0; n < 10 && o_rvalid !== 1'b1; n++) begin
         @(posedge i_clk);
         #1;
      end
      chk(nm, (o_rvalid === 1'b1) ? o_rdata : 16'hdead, exp);
   endtask : rd
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      repeat (90000) @(posedge i_clk);
      chk("watchdog", 16'h0000, 16'h0001);
      summarize();
   end
   initial begin
      {i_rst_n, i_pin_reset, i_cmd_reset, i_wr, i_rd, tx_act, rx_act} = '0;
      {i_addr, i_wdata, err_total, check_count, main_m} = '0;
      strap = 1'b1;
      phy_m = 16'h0100;
      seed = 32'h0f96_136c;
      repeat (10) @(negedge i_clk);
      i_rst_n = 1'b1;
      rd(ADDR_MAIN_CTRL, 16'h0000, "main_por");
      rd(ADDR_PHY_CTRL, 16'h0100, "phy_por");
      rd(ADDR_STATUS, 16'h0000, "clk_ready_early");
      for (int k = 0; k < 7; k++) begin
         seed = lfsr_next(seed);
         wr(ADDR_PHY_CTRL, (k == 6) ? 16'h4900 : seed[15:0] & 16'h4900);
         rd(ADDR_PHY_CTRL, phy_m[15:0], "phy_rw");
         chk("phy_pins", 16'({lpb, pwd, fdx}), 16'({phy_m[14], phy_m[11], phy_m[8]}));
      end
      strap = 1'b0;
      wr(ADDR_PHY_CTRL, 16'hc900);
      chk("phy_rst_busy", 16'(phy_rst), 16'h0001);
      for (n = 0; n < 2000 && phy_rst !== 1'b0; n++) @(negedge i_clk);
      chk("phy_rst_slow", 16'(n > PHY_RST_CYC / 2), 16'h0001);
      rd(ADDR_PHY_CTRL, phy_m[15:0], "phy_defaults");
      for (n = 0; n < 40000 && crdy !== 1'b1; n++) @(negedge i_clk);
      chk("clk_ready", 16'(crdy), 16'h0001);
      foreach (main_seq[i]) begin
         seed = lfsr_next(seed);
         {tx_act, rx_act} = (i % 2 == 1) ? 2'b11 : seed[1:0];
         wr(ADDR_MAIN_CTRL, main_seq[i]);
         rd(ADDR_MAIN_CTRL, main_m[15:0], "main_ctl");
         chk("trx_reset", 16'({tx_rst, rx_rst}), 16'({main_m[7], main_m[6]}));
         chk("trx_abort", 16'({tx_ab, rx_ab}), 16'({main_m[7] & tx_act, main_m[6] & rx_act}));
      end
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_MAIN_CTRL, 16'h000c);
         wr(ADDR_PHY_CTRL, 16'h4800);
         @(negedge i_clk);
         if (k == 0) i_cmd_reset = 1'b1;
         else i_pin_reset = 1'b1;
         @(negedge i_clk);
         {i_cmd_reset, i_pin_reset} = 2'b00;
         for (n = 0; n < 200 && sys_rst !== 1'b1; n++) @(negedge i_clk);
         chk("sys_reset", 16'(sys_rst), 16'h0001);
         for (n = 0; n < 200 && sys_rst !== 1'b0; n++) @(negedge i_clk);
         idle();
         chk("phy_wait", 16'(n >= PHY_WAIT_CYC - 8), 16'h0001);
         main_m = 0;
         phy_m = 0;
         rd(ADDR_MAIN_CTRL, 16'h0000, "main_sys");
         rd(ADDR_PHY_CTRL, 16'h0000, "phy_sys");
         rd(ADDR_STATUS, 16'h0001, "clk_ready_kept");
      end
      summarize();
   end
endmodule : tb_ethernet_controller_reset_unit
`default_nettype wire
